// file: hw/dipg_pkg.sv
// Package for the diagnostic interrupt pulse generator: timing and reset constants
package dipg_pkg;

  // Clock rate of clk_sys in Hz
  localparam int unsigned DIPG_CLK_HZ         = 10_000_000;
  // Least pulse width, in microseconds (30 ms)
  localparam int unsigned DIPG_PULSE_MIN_US   = 30_000;
  // Least pulse width in cycles, never below 1
  localparam int unsigned DIPG_PULSE_CYC      =
    (DIPG_PULSE_MIN_US * (DIPG_CLK_HZ / 1_000_000) + 0) > 0 ?
    DIPG_PULSE_MIN_US * (DIPG_CLK_HZ / 1_000_000) : 1;
  // Debounce time for the front-panel button, in microseconds
  localparam int unsigned DIPG_DEBOUNCE_US    = 10_000;
  // Debounce time in cycles, microseconds times whole MHz
  localparam int unsigned DIPG_DEBOUNCE_CYC   =
    DIPG_DEBOUNCE_US * (DIPG_CLK_HZ / 1_000_000);
  // Width of the pulse counter
  localparam int unsigned DIPG_CNT_W          = 20;
  // Reset value of the pulse counter
  localparam logic [19:0] DIPG_CNT_RST        = 20'h00000;
  // Reset value of the synchroniser chain
  localparam logic [2:0]  DIPG_SYNC_RST       = 3'h0;

  // Generator states
  typedef enum logic [1:0] {
    DIPG_ARMED,
    DIPG_PULSE,
    DIPG_LOCKED
  } dipg_state_t;

endpackage : dipg_pkg

// file: hw/dipg_pin_filter.sv
// Three-stage synchroniser and debounce filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module dipg_pin_filter
  import dipg_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DIPG_DEBOUNCE_CYC,
  parameter int unsigned CNT_W      = 20
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Raw pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  // Refuse a stability window the counter cannot hold
  if (STABLE_CYC < 1 || STABLE_CYC >= (64'd1 << CNT_W)) begin : g_chk
    $error("dipg_pin_filter: STABLE_CYC out of range");
  end

  logic [2:0]       sync_ff;     // Synchroniser chain, bit 0 first
  logic [CNT_W-1:0] stable_ff;   // Cycles the synced level has held
  logic             level_ff;    // Accepted level
  logic [CNT_W-1:0] nxt_stable;  // Next stability count
  logic             nxt_level;   // Next accepted level
  wire              agree;       // Second and third stage agree
  wire              differs;     // Agreed value differs from accepted level

  // Only stages two and three are compared; stage one feeds stage two only
  assign agree   = (sync_ff[1] == sync_ff[2]);
  assign differs = agree && (sync_ff[2] != level_ff);

  // Count how long a new level has stood before taking it
  assign nxt_stable = differs ? stable_ff + 1'b1 : '0;
  assign nxt_level  = (differs && (stable_ff == CNT_W'(STABLE_CYC - 1))) ? sync_ff[2]
                                                                          : level_ff;

  // Synchroniser shift
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_ff <= DIPG_SYNC_RST;
    end else begin
      sync_ff <= {sync_ff[1:0], pin_in};
    end
  end

  // Debounce state; the count restarts on any bounce
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stable_ff <= '0;
      level_ff  <= 1'b0;
    end else begin
      stable_ff <= (nxt_level != level_ff) ? '0 : nxt_stable;
      level_ff  <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule // dipg_pin_filter
`default_nettype wire

// file: hw/dipg_core.sv
// Diagnostic interrupt pulse generator: trigger merge, one-shot and pulse timer
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Hold pulse asserted at least 30 ms
// - One pulse only until host reset/power-down
// - Chassis-control request triggers the pulse
// - Chassis-control trigger logs no event
// - Button press triggers the pulse
// - Button trigger alone raises sensor log event
// - Watchdog pre-timeout triggers only when enabled
module dipg_core
  import dipg_pkg::*;
#(
  parameter int unsigned PULSE_CYC    = DIPG_PULSE_CYC,
  parameter int unsigned DEBOUNCE_CYC = DIPG_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Host re-arm conditions, synchronous levels
  input  wire logic host_reset,
  input  wire logic host_power_down,
  // Chassis-control request from mgmt_controller logic, one-cycle pulse
  input  wire logic chassis_diag_req,
  // Front-panel button pin, active low, asynchronous
  input  wire logic fp_diag_btn_n,
  // Watchdog pre-timeout expiry pulse and action select
  input  wire logic wdt_pretimeout,
  input  wire logic wdt_action_diag,
  // Diagnostic interrupt toward host, active high
  output logic      diag_nmi,
  // Front-panel sensor log event, one-cycle pulse
  output logic      fp_sensor_event,
  // Generator state for status
  output logic      pulse_locked
);

  // Refuse widths the counter cannot hold
  if (PULSE_CYC < 1 || PULSE_CYC >= (64'd1 << DIPG_CNT_W)) begin : g_chk
    $error("dipg_core: PULSE_CYC out of range");
  end

  dipg_state_t           state_ff;      // Generator state
  dipg_state_t           nxt_state;     // Next generator state
  logic [DIPG_CNT_W-1:0] cnt_ff;        // Cycles the pulse has stood
  logic [DIPG_CNT_W-1:0] nxt_cnt;       // Next pulse count
  logic                  btn_level;     // Debounced button, high when pressed
  logic                  btn_prev_ff;   // Last debounced level, for edge detect
  logic                  nmi_ff;        // Registered interrupt output
  logic                  evt_ff;        // Registered log event
  wire                   btn_press;     // Button press edge
  wire                   wdt_trig;      // Watchdog trigger when enabled
  wire                   any_trig;      // Merged trigger
  wire                   rearm;         // Host reset or power-down
  wire                   pulse_done;    // Minimum width reached
  wire                   fire;          // Trigger taken this cycle

  // Button filter; pin is low when pressed
  dipg_pin_filter #(
    .STABLE_CYC (DEBOUNCE_CYC),
    .CNT_W      (DIPG_CNT_W)
  ) u_btn_filter (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pin_in    (~fp_diag_btn_n),
    .level_out (btn_level)
  );

  // Trigger decode
  assign btn_press  = btn_level && !btn_prev_ff;
  assign wdt_trig   = wdt_pretimeout && wdt_action_diag;
  assign any_trig   = chassis_diag_req || btn_press || wdt_trig;
  assign rearm      = host_reset || host_power_down;
  assign pulse_done = (cnt_ff == DIPG_CNT_W'(PULSE_CYC - 1));
  // Only an armed generator takes a trigger
  assign fire       = (state_ff == DIPG_ARMED) && any_trig && !rearm;

  // Next state: armed, pulsing, then locked until re-arm
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      DIPG_ARMED: begin
        // Overlapping triggers merge into one start
        if (fire) begin
          nxt_state = DIPG_PULSE;
          nxt_cnt   = '0;
        end
      end
      DIPG_PULSE: begin
        // Width is finished even if reset arrives, so the host sees 30 ms
        if (pulse_done) begin
          nxt_state = rearm ? DIPG_ARMED : DIPG_LOCKED;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      DIPG_LOCKED: begin
        // Triggers ignored until the host restarts
        if (rearm) begin
          nxt_state = DIPG_ARMED;
        end
      end
      // Unused fourth code: fall back to armed rather than stick
      default: begin
        nxt_state = DIPG_ARMED;
        nxt_cnt   = '0;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= DIPG_ARMED;
      cnt_ff   <= DIPG_CNT_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Registered outputs and edge history
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      btn_prev_ff <= 1'b0;
      nmi_ff      <= 1'b0;
      evt_ff      <= 1'b0;
    end else begin
      btn_prev_ff <= btn_level;
      nmi_ff      <= (nxt_state == DIPG_PULSE);
      // Log only when the button caused a taken pulse; chassis and watchdog stay silent
      evt_ff      <= fire && btn_press;
    end
  end

  assign diag_nmi        = nmi_ff;
  assign fp_sensor_event = evt_ff;
  assign pulse_locked    = (state_ff == DIPG_LOCKED);

endmodule // dipg_core
`default_nettype wire

// file: tb/dipg_monitor.sv
// Port checker for the diagnostic pulse generator
`timescale 1ns/1ps
`default_nettype none
module dipg_monitor #(
  parameter int unsigned PULSE_CYC    = 20,
  parameter int unsigned DEBOUNCE_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Triggers and re-arm
  input wire logic host_reset,
  input wire logic host_power_down,
  input wire logic chassis_diag_req,
  input wire logic fp_diag_btn_n,
  input wire logic wdt_pretimeout,
  input wire logic wdt_action_diag,
  // Outputs
  input wire logic diag_nmi,
  input wire logic fp_sensor_event,
  input wire logic pulse_locked
);
  int  run_ff;  // High cycles so far
  int  hi_ff;   // Released run of the pin
  wire rearm = host_reset | host_power_down;
  wire armed = !diag_nmi & !pulse_locked & !rearm;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counters; pin run saturates, enough to rule out a late press
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_ff <= 0;
      hi_ff  <= 0;
    end else begin
      run_ff <= diag_nmi ? run_ff + 1 : 0;
      hi_ff  <= !fp_diag_btn_n ? 0 : (hi_ff < 31 ? hi_ff + 1 : 31);
    end
  end
  a_pulse_width: assert property ($fell(diag_nmi) |-> run_ff == PULSE_CYC)
    else $error("pulse width wrong");
  a_pulse_hold: assert property ($rose(diag_nmi) |=> diag_nmi [*8])
    else $error("pulse dropped early");
  a_locked_quiet: assert property (pulse_locked && !rearm |=> !diag_nmi)
    else $error("pulse while locked");
  a_rearm_unlock: assert property (pulse_locked && rearm |=> !pulse_locked)
    else $error("no re-arm");
  a_trig_take: assert property (armed && (chassis_diag_req ||
    wdt_pretimeout && wdt_action_diag) |=> $rose(diag_nmi))
    else $error("trigger not taken");
  a_chassis_nolog: assert property ($rose(diag_nmi) && hi_ff > 12 |-> !fp_sensor_event)
    else $error("event without button");
  a_event_pair: assert property (fp_sensor_event |-> $rose(diag_nmi))
    else $error("event apart from pulse");
  a_wdt_masked: assert property (armed && wdt_pretimeout && !wdt_action_diag &&
    !chassis_diag_req && hi_ff > 12 |=> !diag_nmi)
    else $error("masked expiry pulsed");
  // Main scenarios
  c_pulse: cover property ($rose(diag_nmi));
  c_event: cover property (fp_sensor_event);
  c_rearm: cover property (pulse_locked && rearm);
endmodule // dipg_monitor
`default_nettype wire

// file: tb/dipg_host_model.sv
// Host side: counts and times diagnostic pulses
`timescale 1ns/1ps
`default_nettype none
module dipg_host_model (
  // Clock, reset, pulse
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic diag_nmi,
  // Results
  output var int    n_pulse,
  output var int    last_w
);
  int w;  // Running width
  // Width taken at the falling edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      n_pulse <= 0;
      last_w  <= 0;
      w       <= 0;
    end else if (diag_nmi === 1'b1) begin
      w <= w + 1;
    end else if (w != 0) begin
      n_pulse <= n_pulse + 1;
      last_w  <= w;
      w       <= 0;
    end
  end
endmodule // dipg_host_model
`default_nettype wire

// file: tb/dipg_core_test.sv
// Self-checking bench for the diagnostic pulse generator
`timescale 1ns/1ps
`default_nettype none
module dipg_core_test;
  localparam int unsigned PW = 20;  // Short pulse
  localparam int unsigned DB = 4;   // Short debounce
  logic clk_sys = 1'b0, resetn = 1'b0, host_reset = 1'b0, host_power_down = 1'b0;
  logic chassis_diag_req = 1'b0, fp_diag_btn_n = 1'b1;
  logic wdt_pretimeout = 1'b0, wdt_action_diag = 1'b0;
  logic diag_nmi, fp_sensor_event, pulse_locked;
  int   n_pulse, last_w, n_ev = 0, bad_count = 0, n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  // Logged events
  always @(posedge clk_sys) if (fp_sensor_event === 1'b1) n_ev++;
  dipg_core #(.PULSE_CYC(PW), .DEBOUNCE_CYC(DB)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .host_reset(host_reset), .host_power_down(host_power_down),
    .chassis_diag_req(chassis_diag_req), .fp_diag_btn_n(fp_diag_btn_n),
    .wdt_pretimeout(wdt_pretimeout), .wdt_action_diag(wdt_action_diag),
    .diag_nmi(diag_nmi), .fp_sensor_event(fp_sensor_event), .pulse_locked(pulse_locked));
  dipg_host_model i_host (.clk_sys(clk_sys), .resetn(resetn), .diag_nmi(diag_nmi),
    .n_pulse(n_pulse), .last_w(last_w));
  task automatic tick(int n); repeat (n) @(posedge clk_sys); endtask
  task automatic chk_n(string nm, int e, int g);
    n_compared++;
    if (e != g) begin bad_count++; $display("Error %s exp %0d got %0d", nm, e, g); end
  endtask
  task automatic chk_b(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin bad_count++; $display("Error %s exp %b got %b", nm, e, g); end
  endtask
  // One trigger cycle, then wait out the pulse
  task automatic fire(logic c, logic w, logic a);
    chassis_diag_req <= c; wdt_pretimeout <= w; wdt_action_diag <= a;
    tick(1);
    chassis_diag_req <= 1'b0; wdt_pretimeout <= 1'b0;
    tick(PW + 4);
  endtask
  task automatic rearm(logic r, logic p);
    host_reset <= r; host_power_down <= p;
    tick(1);
    host_reset <= 1'b0; host_power_down <= 1'b0;
    tick(2);
  endtask
  task automatic t_chassis;
    fire(1, 0, 0);
    chk_n("pulses", 1, n_pulse);
    chk_n("width", PW, last_w);
    chk_n("events", 0, n_ev);
    chk_b("locked", 1'b1, pulse_locked);
    fire(1, 0, 0);
    chk_n("pulses", 1, n_pulse);
    rearm(1, 0);
    chk_b("locked", 1'b0, pulse_locked);
    $display("t_chassis done");
  endtask
  task automatic t_wdt;
    fire(0, 1, 0);
    chk_n("pulses", 1, n_pulse);
    fire(0, 1, 1);
    chk_n("pulses", 2, n_pulse);
    rearm(0, 1);
    chk_b("locked", 1'b0, pulse_locked);
    $display("t_wdt done");
  endtask
  task automatic t_button;
    fp_diag_btn_n <= 1'b0;
    tick(DB + 12);
    fp_diag_btn_n <= 1'b1;
    tick(PW + 4);
    chk_n("pulses", 3, n_pulse);
    chk_n("events", 1, n_ev);
    rearm(1, 0);
    chk_b("locked", 1'b0, pulse_locked);
    $display("t_button done");
  endtask
  // Chassis, watchdog and button overlap: one pulse
  task automatic t_overlap;
    fp_diag_btn_n <= 1'b0;
    fire(1, 1, 1);
    fp_diag_btn_n <= 1'b1;
    tick(4);
    chk_n("pulses", 4, n_pulse);
    chk_n("width", PW, last_w);
    chk_n("events", 1, n_ev);
    $display("t_overlap done");
  endtask
  // Trigger in the same cycle as a re-arm is refused
  task automatic t_refuse;
    rearm(0, 1);
    chassis_diag_req <= 1'b1; host_reset <= 1'b1;
    tick(1);
    chassis_diag_req <= 1'b0; host_reset <= 1'b0;
    tick(PW + 4);
    chk_n("pulses", 4, n_pulse);
    chk_b("locked", 1'b0, pulse_locked);
    $display("t_refuse done");
  endtask
  // Reset in mid-pulse clears the output and re-arms
  task automatic t_reset;
    chassis_diag_req <= 1'b1;
    tick(1);
    chassis_diag_req <= 1'b0;
    tick(5);
    resetn <= 1'b0;
    tick(2);
    chk_b("nmi", 1'b0, diag_nmi);
    chk_b("locked", 1'b0, pulse_locked);
    resetn <= 1'b1;
    tick(2);
    fire(1, 0, 0);
    chk_n("pulses", 1, n_pulse);
    chk_n("width", PW, last_w);
    $display("t_reset done");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(12);
    resetn <= 1'b1;
    tick(2);
    t_chassis();
    t_wdt();
    t_button();
    t_overlap();
    t_refuse();
    t_reset();
    give_verdict();
  end
  // Watchdog, well past the few hundred cycles needed
  initial begin
    tick(2000);
    bad_count++;
    give_verdict();
  end
endmodule // dipg_core_test
bind dipg_core dipg_monitor #(.PULSE_CYC(PULSE_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) i_mon (
  .clk_sys(clk_sys), .resetn(resetn), .host_reset(host_reset),
  .host_power_down(host_power_down), .chassis_diag_req(chassis_diag_req),
  .fp_diag_btn_n(fp_diag_btn_n), .wdt_pretimeout(wdt_pretimeout),
  .wdt_action_diag(wdt_action_diag), .diag_nmi(diag_nmi),
  .fp_sensor_event(fp_sensor_event), .pulse_locked(pulse_locked));
`default_nettype wire
